/* logic/sfp_ctrl.sv */
// Summary of operation
// - Output bits change on serial clock falling edge
// - Write protect low blocks flagged sectors
// - Write protect low freezes sector protection flags
// - Program or erase ignored under write protect
// - Ignored command ends when chip select rises
// - Protection enable and lockdown still accepted
// - Floating write protect reads as high
// - Reset pin low aborts work, goes idle
// - Held in reset while reset pin low
// - Power-up reset needs nothing on reset pin
// - Array nests sectors, blocks and pages
// - Programming never exceeds one page
// - Erase by chip, sector, block or page
// - Deselected: output floats, input ignored
// - Input sampled on serial clock rising edge
// - Self-timed work finishes, or is aborted by the reset pin, before standby
`timescale 1ns/100ps
`include "sfp_consts.svh"

module sfp_ctrl
(
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic arst_n, // Power-on reset, active low
  input wire logic cs_n, // Chip select pin
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial input pin
  output logic so, // Serial output pin data
  output logic so_oe, // Serial output enable
  input wire logic wp_n, // Write protect pin level
  input wire logic wp_oe, // Host drives write protect
  input wire logic rst_pin_n, // Reset pin
  output sfp_pkg::sfp_rx_type rx, // Received byte
  output sfp_pkg::sfp_launch_type launch, // Operation launch
  input wire sfp_pkg::sfp_core_type core, // Core answer
  output logic ignored, // Command refused pulse
  output logic standby, // Idle and deselected
  output logic [`SFP_NUM_SECTORS-1:0] sect_blocked // Sectors locked
);
  import sfp_pkg::*;

  // --------------------------------------------------------------
  // Registered state
  // --------------------------------------------------------------
  typedef struct packed {
    sfp_state_type st;
    sfp_op_kind_type kind;
    logic [2:0] bitcnt;
    logic [7:0] shin;
    logic [7:0] txsh;
    logic [8:0] idx;
    logic first;
    logic sw_prot;
    logic [`SFP_NUM_SECTORS-1:0] flags;
    logic so;
    sfp_rx_type rx;
    sfp_launch_type launch;
    logic ignored;
  } sfp_ctrl_type;

  sfp_ctrl_type r; // Current state
  sfp_ctrl_type next_r; // Next state

  logic [`SFP_PINS-1:0] pin; // Raw pins
  logic [`SFP_PINS-1:0] lvl; // Synchronised pins
  logic [`SFP_PINS-1:0] rise; // Rising edges
  logic [`SFP_PINS-1:0] fall; // Falling edges
  logic wp_pad; // Write protect after pull-up
  logic wp_on; // Write protect asserted
  logic selected; // Chip select low
  logic in_reset; // Reset pin low
  logic [`SFP_SECT_W-1:0] tgt_sect; // Sector of target page
  logic [10:0] span; // Pages an operation touches
  logic prot_active; // Sector protection in force

  // --------------------------------------------------------------
  // Pin conditioning
  // --------------------------------------------------------------
  // No pull-up exists in RTL, so an undriven pad is modelled here
  assign wp_pad = wp_oe ? wp_n : 1'b1;
  assign pin[`SFP_PIN_CS] = cs_n;
  assign pin[`SFP_PIN_SCK] = sck;
  assign pin[`SFP_PIN_SI] = si;
  assign pin[`SFP_PIN_WP] = wp_pad;
  assign pin[`SFP_PIN_RST] = rst_pin_n;

  // All pins cross into the system clock here
  sfp_pin_sync u_sync
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(pin),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign wp_on = ~lvl[`SFP_PIN_WP];
  assign selected = ~lvl[`SFP_PIN_CS];
  assign in_reset = ~lvl[`SFP_PIN_RST];

  // --------------------------------------------------------------
  // Array geometry
  // --------------------------------------------------------------
  // Sector of the target page: pages / block, blocks / sector
  assign tgt_sect = `SFP_SECT_W'(core.page /
    (`SFP_PAGES_PER_BLOCK * `SFP_BLOCKS_PER_SECTOR));

  // Pages covered per operation; program is always one page
  always_comb
  begin
    span = 11'd1;
    if (r.kind == SFP_OP_ERASE)
    begin
      case (core.erase)
        SFP_ER_PAGE: span = 11'd1;
        SFP_ER_BLOCK: span = 11'(`SFP_PAGES_PER_BLOCK);
        SFP_ER_SECTOR: span = 11'(`SFP_PAGES_PER_BLOCK *
          `SFP_BLOCKS_PER_SECTOR);
        default: span = `SFP_CHIP_PAGES;
      endcase
    end
  end

  // Pin protection acts even without the software enable
  assign prot_active = wp_on | r.sw_prot;
  assign sect_blocked = prot_active ? r.flags : '0;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.rx.valid = 1'b0;
    next_r.launch.start = 1'b0;
    next_r.launch.abort = 1'b0;
    next_r.ignored = 1'b0;
    if (in_reset)
    begin
      // Abort work and hold idle while the pin stays low
      next_r.launch.abort = (r.st != SFP_ST_IDLE);
      next_r.st = SFP_ST_IDLE;
      next_r.so = 1'b0;
    end
    else
    begin
      case (r.st)
        SFP_ST_IDLE:
        begin
          // Frame opens on chip select falling
          if (fall[`SFP_PIN_CS])
          begin
            next_r.st = SFP_ST_RECV;
            next_r.bitcnt = `SFP_BIT_ZERO;
            next_r.first = 1'b1;
            next_r.idx = '0;
            next_r.txsh = '0;
            next_r.kind = SFP_OP_OTHER;
          end
        end
        SFP_ST_RECV, SFP_ST_CLASSIFY:
        begin
          if (r.st == SFP_ST_CLASSIFY)
          begin
            // Core classifies the opcode one cycle after it lands
            next_r.st = SFP_ST_RECV;
            next_r.kind = core.kind;
            if (wp_on && (core.kind == SFP_OP_PROGRAM ||
                core.kind == SFP_OP_ERASE ||
                core.kind == SFP_OP_PROTREG_WR))
            begin
              next_r.st = SFP_ST_IGNORE;
              next_r.ignored = 1'b1;
            end
            // Enable and lockdown fall through untouched
          end
          if (rise[`SFP_PIN_CS])
          begin
            // Frame closes; launch work or return to idle
            next_r.st = SFP_ST_IDLE;
            if (r.kind == SFP_OP_PROGRAM || r.kind == SFP_OP_ERASE)
            begin
              if (sect_blocked[tgt_sect] || wp_on)
              begin
                next_r.ignored = 1'b1;
              end
              else
              begin
                next_r.st = SFP_ST_BUSY;
                next_r.launch.start = 1'b1;
                next_r.launch.kind = r.kind;
                next_r.launch.pages = span;
              end
            end
            else if (r.kind == SFP_OP_PROT_ENABLE)
            begin
              next_r.sw_prot = 1'b1;
            end
            else if (r.kind == SFP_OP_LOCKDOWN)
            begin
              next_r.st = SFP_ST_BUSY;
              next_r.launch.start = 1'b1;
              next_r.launch.kind = r.kind;
              next_r.launch.pages = 11'd1;
            end
          end
          else if (rise[`SFP_PIN_SCK] && selected)
          begin
            // Input bit taken on the rising clock edge
            next_r.shin = {r.shin[6:0], lvl[`SFP_PIN_SI]};
            next_r.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == `SFP_BYTE_LAST)
            begin
              next_r.rx.valid = 1'b1;
              next_r.rx.first = r.first;
              next_r.rx.data = {r.shin[6:0], lvl[`SFP_PIN_SI]};
              next_r.rx.index = r.idx;
              next_r.txsh = core.tx_byte;
              next_r.first = 1'b0;
              if (r.first)
              begin
                next_r.st = SFP_ST_CLASSIFY;
              end
              else
              begin
                // Data index wraps inside one page
                next_r.idx = (r.idx == `SFP_PAGE_BYTES - 9'd1) ?
                  '0 : r.idx + 9'd1;
                if (r.kind == SFP_OP_PROTREG_WR && !wp_on &&
                    r.idx < 9'(`SFP_NUM_SECTORS))
                begin
                  next_r.flags[r.idx[`SFP_SECT_W-1:0]] =
                    |{r.shin[6:0], lvl[`SFP_PIN_SI]};
                end
              end
            end
          end
          else if (fall[`SFP_PIN_SCK] && selected)
          begin
            // Output bit changes on the falling clock edge
            next_r.so = r.txsh[7];
            next_r.txsh = {r.txsh[6:0], 1'b0};
          end
        end
        SFP_ST_IGNORE:
        begin
          // Swallow everything until the frame ends
          if (rise[`SFP_PIN_CS])
          begin
            next_r.st = SFP_ST_IDLE;
          end
        end
        SFP_ST_BUSY:
        begin
          // Chip select is ignored until the core finishes
          if (core.done)
          begin
            next_r.st = SFP_ST_IDLE;
          end
        end
        default:
        begin
          next_r.st = SFP_ST_IDLE;
        end
      endcase
    end
  end

  // State register; power-on reset is the only async reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Drive only while selected inside a live frame
  assign so_oe = selected && !in_reset &&
    (r.st == SFP_ST_RECV || r.st == SFP_ST_CLASSIFY);
  assign so = r.so;
  assign rx = r.rx;
  assign launch = r.launch;
  assign ignored = r.ignored;
  assign standby = (r.st == SFP_ST_IDLE) && !selected;

endmodule

/* logic/sfp_consts.svh */
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry of the main array
// ----------------------------------------------------------------
`define SFP_PAGE_BYTES 9'd264
`define SFP_PAGE_W 10
`define SFP_PAGES_PER_BLOCK 10'd8
`define SFP_BLOCKS_PER_SECTOR 10'd16
`define SFP_NUM_SECTORS 8
`define SFP_SECT_W 3
`define SFP_CHIP_PAGES 11'd1024

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define SFP_BYTE_LAST 3'd7
`define SFP_BIT_ZERO 3'd0

// ----------------------------------------------------------------
// Pin synchroniser lanes and their idle levels
// ----------------------------------------------------------------
`define SFP_PINS 5
`define SFP_PIN_CS 0
`define SFP_PIN_SCK 1
`define SFP_PIN_SI 2
`define SFP_PIN_WP 3
`define SFP_PIN_RST 4
// Serial clock idles low between frames, so no false edge after reset
`define SFP_PIN_IDLE 5'h19

`endif

/* logic/sfp_pkg.sv */
package sfp_pkg;

  // Command class as judged by the flash core from the opcode
  typedef enum logic [2:0] {
    SFP_OP_OTHER,
    SFP_OP_PROGRAM,
    SFP_OP_ERASE,
    SFP_OP_PROTREG_WR,
    SFP_OP_PROT_ENABLE,
    SFP_OP_LOCKDOWN
  } sfp_op_kind_type;

  // Erase granularity
  typedef enum logic [1:0] {
    SFP_ER_PAGE,
    SFP_ER_BLOCK,
    SFP_ER_SECTOR,
    SFP_ER_CHIP
  } sfp_erase_type;

  // Sequencer states
  typedef enum logic [2:0] {
    SFP_ST_IDLE,
    SFP_ST_RECV,
    SFP_ST_CLASSIFY,
    SFP_ST_IGNORE,
    SFP_ST_BUSY
  } sfp_state_type;

  // Received byte towards the core
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
    logic [8:0] index;
  } sfp_rx_type;

  // Operation launch towards the core
  typedef struct packed {
    logic start;
    logic abort;
    sfp_op_kind_type kind;
    logic [10:0] pages;
  } sfp_launch_type;

  // Answer of the core
  typedef struct packed {
    sfp_op_kind_type kind;
    sfp_erase_type erase;
    logic [9:0] page;
    logic [7:0] tx_byte;
    logic done;
  } sfp_core_type;

endpackage

/* logic/sfp_pin_sync.sv */
`timescale 1ns/100ps
`include "sfp_consts.svh"

module sfp_pin_sync
(
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Asynchronous reset
  input wire logic [`SFP_PINS-1:0] pin, // Raw pin levels
  output logic [`SFP_PINS-1:0] level, // Synchronised levels
  output logic [`SFP_PINS-1:0] rise, // One-cycle rising edge
  output logic [`SFP_PINS-1:0] fall // One-cycle falling edge
);
  import sfp_pkg::*;

  // --------------------------------------------------------------
  // Three stages: two for metastability, one for edge history
  // --------------------------------------------------------------
  typedef struct packed {
    logic [`SFP_PINS-1:0] s1;
    logic [`SFP_PINS-1:0] s2;
    logic [`SFP_PINS-1:0] s3;
  } sfp_sync_type;

  sfp_sync_type r; // Registered stages
  sfp_sync_type next_r; // Next stages

  // Shift every lane one stage on
  always_comb
  begin
    next_r = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  // Idle levels keep a fresh reset from faking edges
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= {3{`SFP_PIN_IDLE}};
    end
    else
    begin
      r <= next_r;
    end
  end

  // Edge detection only looks at stages two and three
  genvar g;
  generate
    for (g = 0; g < `SFP_PINS; g++)
    begin : lane
      assign level[g] = r.s2[g];
      assign rise[g] = r.s2[g] & ~r.s3[g];
      assign fall[g] = ~r.s2[g] & r.s3[g];
    end
  endgenerate

endmodule

/* verif/sfp_ctrl_sva.sv */
`timescale 1ns/100ps

module sfp_ctrl_sva
(
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic cs_n, // Select pin
  input wire logic sck, // Link clock pin
  input wire logic so, // Output data
  input wire logic so_oe, // Output enable
  input wire logic wp_n, // Protect pin
  input wire logic wp_oe, // Protect driven
  input wire logic rst_pin_n, // Reset pin
  input wire sfp_pkg::sfp_rx_type rx, // Byte out
  input wire sfp_pkg::sfp_launch_type launch, // Launch
  input wire sfp_pkg::sfp_core_type core, // Core answer
  input wire logic standby // Idle flag
);
  import sfp_pkg::*;
  // Floating pad counts as high
  wire wp_eff = wp_n || !wp_oe;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Pin level checks
  // ----------------------------------------
  a_so_fall_edge: assert property ($changed(so) |-> !sck)
    else $error("so moved while sck high");
  a_desel_float: assert property (cs_n [*4] |-> !so_oe)
    else $error("so driven while deselected");
  a_rx_selected: assert property (rx.valid |-> !cs_n)
    else $error("byte taken while deselected");
  a_rst_float: assert property (!rst_pin_n [*4] |-> !so_oe)
    else $error("so driven in reset");
  a_reset_quiet: assert property (!rst_pin_n [*5] |->
    !rx.valid && !launch.start)
    else $error("activity in reset");
  a_abort_work: assert property ($fell(rst_pin_n) && !standby |->
    ##[1:5] launch.abort)
    else $error("no abort on reset pin");
  // ----------------------------------------
  // Launch checks
  // ----------------------------------------
  a_wp_blocks: assert property (launch.start &&
    (launch.kind == SFP_OP_PROGRAM || launch.kind == SFP_OP_ERASE)
    |-> $past(wp_eff, 3))
    else $error("write launched under protect");
  a_one_page: assert property (launch.start &&
    launch.kind == SFP_OP_PROGRAM |-> launch.pages == 11'h001)
    else $error("program over one page");
  a_end_on_cs: assert property (launch.start |->
    cs_n && $past(cs_n, 3))
    else $error("launch before select rise");
  a_busy_holds: assert property (launch.start && !core.done |=>
    !standby)
    else $error("standby while busy");
endmodule

/* verif/sfp_host.sv */
`timescale 1ns/100ps

module sfp_host
(
  input wire logic sys_clk, // Clock
  output logic cs_n, // Select
  output logic sck, // Link clock
  output logic si // Serial data
);
  // Link clock idles low outside frames
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // One frame: opcode, then nd data bytes
  // ----------------------------------------
  task automatic frame(input logic [7:0] op, input int nd,
    input logic [7:0] dat);
    logic [7:0] b;
    wt(1);
    cs_n <= 1'b0;
    for (int k = 0; k <= nd; k++)
    begin
      b = (k == 0) ? op : dat;
      for (int i = 7; i >= 0; i--)
      begin
        sck <= 1'b0;
        si <= b[i];
        wt(4);
        sck <= 1'b1;
        wt(4);
      end
    end
    sck <= 1'b0;
    wt(4);
    cs_n <= 1'b1;
    // Released line flips once, never a stale bit
    si <= ~si;
    wt(8);
  endtask
endmodule

/* verif/test_serial_flash_protect_reset_ctrl.sv */
`timescale 1ns/100ps

module test_serial_flash_protect_reset_ctrl;
  import sfp_pkg::*;
  logic sys_clk, arst_n, wp_n, wp_oe, rst_pin_n;
  logic cs_n, sck, si, so, so_oe, ignored, standby, oe_seen;
  logic [7:0] sect_blocked, last_op, so_cap, fill;
  sfp_core_type core;
  sfp_rx_type rx;
  sfp_launch_type launch;
  sfp_op_kind_type last_kind;
  logic [10:0] last_pages;
  int errors, num_checks, n_start, n_ign, n_abort, n_rx, s, g;
  sfp_ctrl u_sfp_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .wp_oe(wp_oe), .rst_pin_n(rst_pin_n), .rx(rx), .launch(launch),
    .core(core), .ignored(ignored), .standby(standby),
    .sect_blocked(sect_blocked));
  sfp_host u_sfp_host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck),
    .si(si));
  always #10 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Event counters, one driver each
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    n_start <= n_start + int'(launch.start);
    n_ign <= n_ign + int'(ignored);
    n_abort <= n_abort + int'(launch.abort);
    n_rx <= n_rx + int'(rx.valid);
    if (launch.start)
    begin
      last_kind <= launch.kind;
      last_pages <= launch.pages;
    end
    if (rx.valid && rx.first)
      last_op <= rx.data;
  end
  // Output bit and enable as the host sees them on each sck rise
  always @(posedge sck)
  begin
    so_cap <= {so_cap[6:0], so};
    oe_seen <= so_oe;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input sfp_op_kind_type k, input int nd);
    core.kind <= k;
    s = n_start;
    g = n_ign;
    u_sfp_host.frame(8'hC3, nd, fill);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_prog;
    core.done <= 1'b0;
    send(SFP_OP_PROGRAM, 0);
    chk(n_start - s, 1);
    chk(last_pages, 11'h001);
    chk(last_op, 8'hC3);
    chk(standby, 1'b0);
    core.done <= 1'b1;
    wt(4);
    chk(standby, 1'b1);
    // Erase spans follow the array geometry
    core.erase <= SFP_ER_BLOCK;
    send(SFP_OP_ERASE, 0);
    chk(last_kind, SFP_OP_ERASE);
    chk(last_pages, 11'h008);
    core.erase <= SFP_ER_SECTOR;
    send(SFP_OP_ERASE, 0);
    chk(last_pages, 11'h080);
    core.erase <= SFP_ER_CHIP;
    send(SFP_OP_ERASE, 0);
    chk(last_pages, 11'h400);
    core.erase <= SFP_ER_PAGE;
    send(SFP_OP_ERASE, 0);
    chk(last_pages, 11'h001);
    $display("test prog done");
  endtask
  task automatic t_wp;
    wp_n <= 1'b0;
    for (int k = 1; k <= 2; k++)
    begin
      send(sfp_op_kind_type'(k), 0);
      chk(n_start - s, 0);
      chk(n_ign - g, 1);
      chk(standby, 1'b1);
    end
    send(SFP_OP_PROTREG_WR, 9);
    chk(sect_blocked, 8'h00);
    $display("test wp done");
  endtask
  task automatic t_flags;
    wp_n <= 1'b1;
    send(SFP_OP_PROTREG_WR, 9);
    chk(sect_blocked, 8'h00);
    chk(so_cap, 8'hA5);
    chk(oe_seen, 1'b1);
    wp_oe <= 1'b0;
    wp_n <= 1'b0;
    send(SFP_OP_PROGRAM, 0);
    chk(n_start - s, 1);
    wp_oe <= 1'b1;
    wt(6);
    chk(sect_blocked, 8'hFF);
    $display("test flags done");
  endtask
  task automatic t_lock;
    send(SFP_OP_PROT_ENABLE, 0);
    send(SFP_OP_LOCKDOWN, 0);
    chk(last_kind, SFP_OP_LOCKDOWN);
    // Clearing write under protect must leave every flag set
    fill = 8'h00;
    send(SFP_OP_PROTREG_WR, 9);
    chk(n_ign - g, 1);
    chk(sect_blocked, 8'hFF);
    fill = 8'hFF;
    wp_n <= 1'b1;
    wt(6);
    chk(sect_blocked, 8'hFF);
    core.page <= 10'h080;
    send(SFP_OP_PROGRAM, 0);
    chk(n_start - s, 0);
    chk(n_ign - g, 1);
    $display("test lock done");
  endtask
  task automatic t_reset;
    core.done <= 1'b0;
    send(SFP_OP_LOCKDOWN, 0);
    s = n_abort;
    rst_pin_n <= 1'b0;
    wt(8);
    chk(n_abort - s, 1);
    s = n_rx;
    u_sfp_host.frame(8'h5A, 0, fill);
    chk(n_rx - s, 0);
    chk(so_oe, 1'b0);
    chk(oe_seen, 1'b0);
    rst_pin_n <= 1'b1;
    core.done <= 1'b1;
    wt(6);
    chk(standby, 1'b1);
    send(SFP_OP_LOCKDOWN, 0);
    chk(n_start - s, 1);
    $display("test reset done");
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, well past the few thousand cycles needed
  initial
  begin
    #1000000;
    errors++;
    stop_test;
  end
  initial
  begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    wp_n = 1'b1;
    wp_oe = 1'b1;
    rst_pin_n = 1'b1;
    fill = 8'hFF;
    core = '{SFP_OP_OTHER, SFP_ER_PAGE, 10'h000, 8'hA5, 1'b0};
    wt(12);
    arst_n <= 1'b1;
    wt(4);
    t_prog;
    t_wp;
    t_flags;
    t_lock;
    t_reset;
    stop_test;
  end
endmodule

bind sfp_ctrl sfp_ctrl_sva u_sfp_ctrl_sva (.sys_clk(sys_clk),
  .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .so(so), .so_oe(so_oe),
  .wp_n(wp_n), .wp_oe(wp_oe), .rst_pin_n(rst_pin_n), .rx(rx),
  .launch(launch), .core(core), .standby(standby));
